// ### rtl/qps_consts.svh
`ifndef QPS_CONSTS_SVH
`define QPS_CONSTS_SVH

// command selects for the decoded remote command port
`define QPS_SEL_PWR_COND 4'h0
`define QPS_SEL_PWR_RISE 4'h1
`define QPS_SEL_PWR_FALL 4'h2
`define QPS_SEL_PWR_EVENT 4'h3
`define QPS_SEL_PWR_MASK 4'h4
`define QPS_SEL_FRQ_COND 4'h5
`define QPS_SEL_FRQ_RISE 4'h6
`define QPS_SEL_FRQ_FALL 4'h7
`define QPS_SEL_FRQ_EVENT 4'h8
`define QPS_SEL_FRQ_MASK 4'h9
`define QPS_SEL_PROT_CLR 4'ha

// power condition bit positions
`define QPS_PWR_TRIP_BIT 0
`define QPS_PWR_UNLEVEL_BIT 1

// frequency condition bit positions
`define QPS_FRQ_SYNTH_BIT 0
`define QPS_FRQ_REF10M_BIT 1
`define QPS_FRQ_REF1G_BIT 2
`define QPS_FRQ_BB1_BIT 3
`define QPS_FRQ_SAMPLER_BIT 5
`define QPS_FRQ_TUNED_OSC_BIT 6

// summary positions in the parent questionable condition word
`define QPS_SUM_PWR_BIT 3
`define QPS_SUM_FRQ_BIT 5

// reset values of the writable registers, and the all-zero word
`define QPS_RISE_RST 16'hffff
`define QPS_FALL_RST 16'h0000
`define QPS_MASK_RST 16'h0000
`define QPS_WORD_ZERO 16'h0000

`endif

// ### rtl/qps_pkg.sv
package qps_pkg;

    // decoded remote command: one request per valid cycle
    typedef struct packed {
        logic valid;
        logic write;
        logic [3:0] sel;
        logic [15:0] wdata;
    } qps_cmd_type;

    // answer to a command, one cycle after it is taken
    typedef struct packed {
        logic valid;
        logic refused;
        logic [15:0] data;
    } qps_rsp_type;

    // live hardware flags, raw from the rf and synthesizer sections
    typedef struct packed {
        logic overload;
        logic unlevel;
        logic synth;
        logic ref10m;
        logic ref1g;
        logic bb1;
        logic sampler;
        logic tuned_osc_loop;
    } qps_flags_type;

endpackage

// ### rtl/qps_status.sv
`timescale 1ns/100ps
`include "qps_consts.svh"

// one status group: filters, event latch, enable mask and summary
module qps_group (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // live condition word
    input wire logic [15:0] cond_i,
    // register strobes
    input wire logic wr_rise_i,
    input wire logic wr_fall_i,
    input wire logic wr_mask_i,
    input wire logic rd_event_i,
    input wire logic [15:0] wdata_i,
    // register contents
    output logic [15:0] rise_filter_o,
    output logic [15:0] fall_filter_o,
    output logic [15:0] event_mask_o,
    output logic [15:0] event_latch_o,
    // group summary
    output logic summary_o
);

    logic [15:0] prev_q;
    logic [15:0] rise_filter_q;
    logic [15:0] fall_filter_q;
    logic [15:0] event_mask_q;
    logic [15:0] event_latch_q;
    logic [15:0] event_latch_d;
    logic [15:0] rise_hit;
    logic [15:0] fall_hit;

    // qualified transitions against the previous cycle's condition
    assign rise_hit = cond_i & ~prev_q & rise_filter_q;
    assign fall_hit = ~cond_i & prev_q & fall_filter_q;

    // a new event in the read cycle survives the clear, so none is lost
    assign event_latch_d = (rd_event_i ? `QPS_WORD_ZERO : event_latch_q)
        | rise_hit | fall_hit;

    // summary drops the cycle after a read clears the latch
    assign summary_o = |(event_latch_q & event_mask_q);

    // register contents go straight out to the query mux
    assign rise_filter_o = rise_filter_q;
    assign fall_filter_o = fall_filter_q;
    assign event_mask_o = event_mask_q;
    assign event_latch_o = event_latch_q;

    // condition history and event latch
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_q <= `QPS_WORD_ZERO;
            event_latch_q <= `QPS_WORD_ZERO;
        end else begin
            prev_q <= cond_i;
            event_latch_q <= event_latch_d;
        end
    end

    // filters and mask keep the whole written word
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rise_filter_q <= `QPS_RISE_RST;
            fall_filter_q <= `QPS_FALL_RST;
            event_mask_q <= `QPS_MASK_RST;
        end else begin
            if (wr_rise_i) begin
                rise_filter_q <= wdata_i;
            end
            if (wr_fall_i) begin
                fall_filter_q <= wdata_i;
            end
            if (wr_mask_i) begin
                event_mask_q <= wdata_i;
            end
        end
    end

endmodule

// power and frequency questionable status groups behind the command port
module qps_status (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // raw hardware flags from outside this clock domain
    input wire qps_pkg::qps_flags_type flags_i,
    // decoded remote command and its answer
    input wire qps_pkg::qps_cmd_type cmd_i,
    output qps_pkg::qps_rsp_type rsp_o,
    // parent questionable event enable mask
    input wire logic [15:0] parent_mask_i,
    // summaries and protection state
    output logic pwr_summary_o,
    output logic frq_summary_o,
    output logic stb_ques_o,
    output logic rf_out_enable_o
);

    // three-stage synchroniser and agreement filter
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] sync3_q;
    logic [7:0] flt_q;
    logic [7:0] flt_d;
    qps_pkg::qps_flags_type flt;

    // protection latch and response
    logic overload_protect_trip_q;
    logic overload_protect_trip_d;
    qps_pkg::qps_rsp_type rsp_q;
    qps_pkg::qps_rsp_type rsp_d;

    // condition words
    logic [15:0] pwr_cond;
    logic [15:0] frq_cond;

    // group register contents
    logic [15:0] pwr_rise;
    logic [15:0] pwr_fall;
    logic [15:0] pwr_mask;
    logic [15:0] pwr_event;
    logic [15:0] frq_rise;
    logic [15:0] frq_fall;
    logic [15:0] frq_mask;
    logic [15:0] frq_event;

    // command decode
    logic cmd_rd;
    logic cmd_wr;
    logic sel_known;
    logic sel_writable;
    logic prot_clear;
    logic [15:0] rd_data;
    logic wr_refused;
    logic rd_refused;

    // per-group register strobes
    logic pwr_wr_rise;
    logic pwr_wr_fall;
    logic pwr_wr_mask;
    logic pwr_rd_event;
    logic frq_wr_rise;
    logic frq_wr_fall;
    logic frq_wr_mask;
    logic frq_rd_event;

    // a flag only changes once stages two and three agree, rejecting glitches
    assign flt_d = (sync2_q & sync3_q) | (flt_q & (sync2_q | sync3_q));
    assign flt = flt_q;

    // only stage two reads stage one, so a metastable first stage never fans out
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            sync3_q <= 8'h00;
            flt_q <= 8'h00;
        end else begin
            sync1_q <= flags_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            flt_q <= flt_d;
        end
    end

    // command strobes
    assign cmd_rd = cmd_i.valid & ~cmd_i.write;
    assign cmd_wr = cmd_i.valid & cmd_i.write;
    assign prot_clear = cmd_wr & (cmd_i.sel == `QPS_SEL_PROT_CLR);

    // refused writes and reads decode to no strobe at all
    assign pwr_wr_rise = cmd_wr & (cmd_i.sel == `QPS_SEL_PWR_RISE);
    assign pwr_wr_fall = cmd_wr & (cmd_i.sel == `QPS_SEL_PWR_FALL);
    assign pwr_wr_mask = cmd_wr & (cmd_i.sel == `QPS_SEL_PWR_MASK);
    assign pwr_rd_event = cmd_rd & (cmd_i.sel == `QPS_SEL_PWR_EVENT);
    assign frq_wr_rise = cmd_wr & (cmd_i.sel == `QPS_SEL_FRQ_RISE);
    assign frq_wr_fall = cmd_wr & (cmd_i.sel == `QPS_SEL_FRQ_FALL);
    assign frq_wr_mask = cmd_wr & (cmd_i.sel == `QPS_SEL_FRQ_MASK);
    assign frq_rd_event = cmd_rd & (cmd_i.sel == `QPS_SEL_FRQ_EVENT);

    // trip holds after the overload goes away; a live overload beats a clear
    assign overload_protect_trip_d = flt.overload
        | (overload_protect_trip_q & ~prot_clear);

    // trip latch: only the protection clear command lets it fall
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            overload_protect_trip_q <= 1'b0;
        end else begin
            overload_protect_trip_q <= overload_protect_trip_d;
        end
    end

    // no rf while tripped
    assign rf_out_enable_o = ~overload_protect_trip_q;

    // condition words are built from live state only, never written
    assign pwr_cond = {14'h0000, flt.unlevel, overload_protect_trip_q};
    assign frq_cond = {9'h000, flt.tuned_osc_loop, flt.sampler, 1'b0,
        flt.bb1, flt.ref1g, flt.ref10m, flt.synth};

    // power group
    qps_group u_pwr (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .cond_i(pwr_cond),
        .wr_rise_i(pwr_wr_rise),
        .wr_fall_i(pwr_wr_fall),
        .wr_mask_i(pwr_wr_mask),
        .rd_event_i(pwr_rd_event),
        .wdata_i(cmd_i.wdata),
        .rise_filter_o(pwr_rise),
        .fall_filter_o(pwr_fall),
        .event_mask_o(pwr_mask),
        .event_latch_o(pwr_event),
        .summary_o(pwr_summary_o)
    );

    // frequency group
    qps_group u_frq (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .cond_i(frq_cond),
        .wr_rise_i(frq_wr_rise),
        .wr_fall_i(frq_wr_fall),
        .wr_mask_i(frq_wr_mask),
        .rd_event_i(frq_rd_event),
        .wdata_i(cmd_i.wdata),
        .rise_filter_o(frq_rise),
        .fall_filter_o(frq_fall),
        .event_mask_o(frq_mask),
        .event_latch_o(frq_event),
        .summary_o(frq_summary_o)
    );

    // parent enable mask gates the two summaries onto the status byte bit
    assign stb_ques_o = (pwr_summary_o & parent_mask_i[`QPS_SUM_PWR_BIT])
        | (frq_summary_o & parent_mask_i[`QPS_SUM_FRQ_BIT]);

    // query mux
    assign rd_data =
        (cmd_i.sel == `QPS_SEL_PWR_COND) ? pwr_cond :
        (cmd_i.sel == `QPS_SEL_PWR_RISE) ? pwr_rise :
        (cmd_i.sel == `QPS_SEL_PWR_FALL) ? pwr_fall :
        (cmd_i.sel == `QPS_SEL_PWR_EVENT) ? pwr_event :
        (cmd_i.sel == `QPS_SEL_PWR_MASK) ? pwr_mask :
        (cmd_i.sel == `QPS_SEL_FRQ_COND) ? frq_cond :
        (cmd_i.sel == `QPS_SEL_FRQ_RISE) ? frq_rise :
        (cmd_i.sel == `QPS_SEL_FRQ_FALL) ? frq_fall :
        (cmd_i.sel == `QPS_SEL_FRQ_EVENT) ? frq_event :
        (cmd_i.sel == `QPS_SEL_FRQ_MASK) ? frq_mask :
        `QPS_WORD_ZERO;

    // selects that exist at all, and those that take a write
    assign sel_known = (cmd_i.sel <= `QPS_SEL_PROT_CLR);
    assign sel_writable =
        (cmd_i.sel == `QPS_SEL_PWR_RISE) | (cmd_i.sel == `QPS_SEL_PWR_FALL) |
        (cmd_i.sel == `QPS_SEL_PWR_MASK) | (cmd_i.sel == `QPS_SEL_FRQ_RISE) |
        (cmd_i.sel == `QPS_SEL_FRQ_FALL) | (cmd_i.sel == `QPS_SEL_FRQ_MASK) |
        (cmd_i.sel == `QPS_SEL_PROT_CLR);

    // writes to condition or event words are refused and change nothing
    assign rsp_d.valid = cmd_i.valid;
    assign wr_refused = ~sel_writable;
    assign rd_refused = ~sel_known | (cmd_i.sel == `QPS_SEL_PROT_CLR);
    assign rsp_d.refused = cmd_i.valid & (cmd_i.write ? wr_refused : rd_refused);
    assign rsp_d.data = cmd_rd ? rd_data : `QPS_WORD_ZERO;

    // answer is registered so its data comes from flip-flops
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign rsp_o = rsp_q;

endmodule

// ### verif/qps_status_chk.sv
`timescale 1ns/100ps
`include "qps_consts.svh"

// watches the command port, the answers and the summary levels
module qps_status_chk (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // inputs of the block
    input wire qps_pkg::qps_flags_type flags_i,
    input wire qps_pkg::qps_cmd_type cmd_i,
    input wire logic [15:0] parent_mask_i,
    // outputs of the block
    input wire qps_pkg::qps_rsp_type rsp_o,
    input wire logic pwr_summary_o,
    input wire logic frq_summary_o,
    input wire logic stb_ques_o,
    input wire logic rf_out_enable_o
);
    logic [15:0] shadow_q [16];
    logic [3:0] ovl_age_q;
    wire logic rd_w = cmd_i.valid & ~cmd_i.write;
    wire logic wr_w = cmd_i.valid & cmd_i.write;
    wire logic clr_w = wr_w & (cmd_i.sel == `QPS_SEL_PROT_CLR);
    wire logic rw_w = cmd_i.sel inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h7, 4'h9};

    // shadow of writable words; the age counter bounds the trip delay
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 16; i++) begin
                shadow_q[i] <= (i == 1 || i == 6) ? `QPS_RISE_RST : `QPS_MASK_RST;
            end
            ovl_age_q <= 4'hf;
        end else begin
            if (wr_w && rw_w) begin
                shadow_q[cmd_i.sel] <= cmd_i.wdata;
            end
            ovl_age_q <= flags_i.overload ? 4'h0 : ovl_age_q + {3'h0, ovl_age_q != 4'hf};
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    rsp_every_a: assert property (cmd_i.valid |=> rsp_o.valid)
        else $error("no answer one cycle after a command");
    rf_down_a: assert property ($fell(rf_out_enable_o) |-> ovl_age_q < 4'h8)
        else $error("rf output dropped without an overload");
    rf_up_a: assert property ($rose(rf_out_enable_o) |-> $past(clr_w) || $past(clr_w, 2))
        else $error("rf output returned without a clear command");
    pwr_unused_a: assert property (rd_w && cmd_i.sel == 4'h0 |=> rsp_o.data[15:2] == 14'h0)
        else $error("unused power condition bit set");
    frq_unused_a: assert property (rd_w && cmd_i.sel == 4'h5 |=>
        rsp_o.data[15:7] == 9'h0 && !rsp_o.data[4])
        else $error("unused frequency condition bit set");
    cond_ro_a: assert property (wr_w && cmd_i.sel == 4'h0 |=> rsp_o.refused)
        else $error("condition write not refused");
    mask_echo_a: assert property (rd_w && rw_w |=>
        rsp_o.data == shadow_q[$past(cmd_i.sel)])
        else $error("writable word reads back a wrong value");
    stb_gate_a: assert property (stb_ques_o ==
        ((pwr_summary_o & parent_mask_i[3]) | (frq_summary_o & parent_mask_i[5])))
        else $error("status byte contribution wrong");

    cover property (clr_w);
    cover property ($fell(pwr_summary_o));
    cover property (rd_w && cmd_i.sel == `QPS_SEL_FRQ_EVENT && frq_summary_o);
endmodule

bind qps_status qps_status_chk chk (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .flags_i(flags_i),
    .cmd_i(cmd_i),
    .parent_mask_i(parent_mask_i),
    .rsp_o(rsp_o),
    .pwr_summary_o(pwr_summary_o),
    .frq_summary_o(frq_summary_o),
    .stb_ques_o(stb_ques_o),
    .rf_out_enable_o(rf_out_enable_o)
);

// ### verif/qps_ctl_model.sv
`timescale 1ns/100ps

// remote controller: sends parsed commands, one word each
module qps_ctl_model (
    // clock
    input wire logic sys_clk_i,
    // answer from the block
    input wire qps_pkg::qps_rsp_type rsp_i,
    // command to the block
    output qps_pkg::qps_cmd_type cmd_o
);
    initial cmd_o = '0;

    // hold the request to the taking edge, then wait a bounded time for the answer
    task automatic xfer(input logic wr, input logic [3:0] sel, input logic [15:0] wdata,
            output qps_pkg::qps_rsp_type rsp);
        int n;
        @(posedge sys_clk_i);
        cmd_o <= '{valid: 1'b1, write: wr, sel: sel, wdata: wdata};
        @(posedge sys_clk_i);
        cmd_o <= '0;
        n = 0;
        #1 rsp = rsp_i;
        while (!rsp.valid && n < 4) begin
            @(posedge sys_clk_i);
            #1 rsp = rsp_i;
            n++;
        end
    endtask
endmodule

// ### verif/questionable_power_freq_status_bench.sv
`timescale 1ns/100ps
`include "qps_consts.svh"

module questionable_power_freq_status_bench;
    logic sys_clk_i;
    logic arst_n_i;
    qps_pkg::qps_flags_type flags_i;
    qps_pkg::qps_cmd_type cmd_i;
    qps_pkg::qps_rsp_type rsp_o;
    qps_pkg::qps_rsp_type r;
    logic [15:0] parent_mask_i;
    logic pwr_sum, frq_sum, stb_ques, rf_en;
    int err_total;
    int n_checks;
    int cpos [6] = '{0, 1, 2, 3, 5, 6};

    qps_status dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .flags_i(flags_i),
        .cmd_i(cmd_i), .rsp_o(rsp_o), .parent_mask_i(parent_mask_i),
        .pwr_summary_o(pwr_sum), .frq_summary_o(frq_sum), .stb_ques_o(stb_ques),
        .rf_out_enable_o(rf_en));
    qps_ctl_model ctl (.sys_clk_i(sys_clk_i), .rsp_i(rsp_o), .cmd_o(cmd_i));

    // 10 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask

    task automatic rd(input logic [3:0] sel, input logic [15:0] exp);
        ctl.xfer(1'b0, sel, 16'h0000, r);
        chk("answer", {15'h0, r.valid}, 16'h0001);
        chk($sformatf("word %h", sel), r.data, exp);
    endtask

    task automatic wr(input logic [3:0] sel, input logic [15:0] d);
        ctl.xfer(1'b1, sel, d, r);
        chk("answer", {15'h0, r.valid}, 16'h0001);
    endtask

    // flags pass a four edge filter before the condition word sees them
    task automatic settle;
        repeat (8) @(posedge sys_clk_i);
    endtask

    task end_sim;
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // the tests need about 300 cycles
    initial begin
        repeat (6000) @(posedge sys_clk_i);
        err_total++;
        end_sim;
    end

    initial begin
        arst_n_i = 1'b0;
        flags_i = '0;
        parent_mask_i = 16'h0028;
        repeat (12) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        // reset contents of every readable word
        for (int s = 0; s < 10; s++) begin
            rd(s[3:0], (s == 1 || s == 6) ? `QPS_RISE_RST : `QPS_WORD_ZERO);
        end
        // a condition word refuses writes
        ctl.xfer(1'b1, 4'h0, 16'h0003, r);
        chk("refused", {15'h0, r.refused}, 16'h0001);
        rd(4'h0, `QPS_WORD_ZERO);
        // masks take a sum of bit weights and read it back
        wr(4'h4, 16'h0003);
        rd(4'h4, 16'h0003);
        wr(4'h9, 16'h006f);
        rd(4'h9, 16'h006f);
        // each frequency source alone: rise latched, read clears, fall ignored
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk_i) flags_i[5-i] <= 1'b1;
            settle;
            rd(4'h5, 16'h0001 << cpos[i]);
            chk("frq sum", {15'h0, frq_sum}, 16'h0001);
            chk("stb", {15'h0, stb_ques}, 16'h0001);
            rd(4'h8, 16'h0001 << cpos[i]);
            rd(4'h8, `QPS_WORD_ZERO);
            chk("frq sum", {15'h0, frq_sum}, 16'h0000);
            @(posedge sys_clk_i) flags_i[5-i] <= 1'b0;
            settle;
            rd(4'h8, `QPS_WORD_ZERO);
        end
        // sampler on the fall filter only: latched on 1 to 0 and held
        wr(4'h6, 16'h0000);
        wr(4'h7, 16'h0020);
        @(posedge sys_clk_i) flags_i.sampler <= 1'b1;
        settle;
        rd(4'h8, `QPS_WORD_ZERO);
        @(posedge sys_clk_i) flags_i.sampler <= 1'b0;
        settle;
        rd(4'h5, `QPS_WORD_ZERO);
        rd(4'h8, 16'h0020);
        // power filters: rise on both bits, fall on unlevel only
        wr(4'h1, 16'h0003);
        rd(4'h1, 16'h0003);
        wr(4'h2, 16'h0002);
        // unlevel raises the power summary until its event is read
        @(posedge sys_clk_i) flags_i.unlevel <= 1'b1;
        settle;
        rd(4'h0, 16'h0002);
        chk("pwr sum", {15'h0, pwr_sum}, 16'h0001);
        chk("stb", {15'h0, stb_ques}, 16'h0001);
        @(posedge sys_clk_i) parent_mask_i <= 16'h0020;
        #1 chk("stb", {15'h0, stb_ques}, 16'h0000);
        rd(4'h3, 16'h0002);
        chk("pwr sum", {15'h0, pwr_sum}, 16'h0000);
        @(posedge sys_clk_i) flags_i.unlevel <= 1'b0;
        settle;
        rd(4'h3, 16'h0002);
        // an overload pulse trips protection until the clear command
        @(posedge sys_clk_i) flags_i.overload <= 1'b1;
        settle;
        @(posedge sys_clk_i) flags_i.overload <= 1'b0;
        settle;
        rd(4'h0, 16'h0001);
        chk("rf en", {15'h0, rf_en}, 16'h0000);
        chk("pwr sum", {15'h0, pwr_sum}, 16'h0001);
        wr(`QPS_SEL_PROT_CLR, 16'h0000);
        rd(4'h0, `QPS_WORD_ZERO);
        chk("rf en", {15'h0, rf_en}, 16'h0001);
        rd(4'h3, 16'h0001);
        end_sim;
    end
endmodule
